// [design/can_message_buffer_control.v]
`include "can_buf_defines.vh"
`default_nettype none
// What this block does
// - write to full buffer sets overflow flag
// - overflow flags cleared only by software zero
// - buffers 0-15 low reg, 16-31 high
// - control register: even low byte, odd high
// - direction bit one means transmit buffer
// - aborted flag set on abort, zero otherwise
// - lost-arbitration flag set on lost arbitration
// - bus-error flag set on transmit error
// - send request set by software, cleared on success
// - clearing pending send request means abort
// - setting send request clears status flags
// - remote frame sets send request if enabled
// - two-bit priority, 11 highest, 00 lowest
// - message words live in message ram
// - id word: sid 12-2, srr 1, ide 0
// - ide selects extended or standard identifier
// - extended id split across eid and length words
// - length bit 9 marks remote request of extended frames
// - dlc in bits 3-0, bits 7-5 zero
// - full flag set on store, cleared by software
module can_message_buffer_control #(
   parameter NBUF_TX = 8,                       // buffers with control bytes
   parameter NBUF_RX = 32,                      // buffers with full/overflow flags
   parameter RAM_AW  = 8                        // message ram word address width
) (
   input  wire        ref_clk_i,                // system clock
   input  wire        rst_b_i,                  // sync reset, active low
   // avalon-mm slave
   input  wire [5:0]  avs_address_i,            // word address
   input  wire        avs_read_i,               // read strobe
   input  wire        avs_write_i,              // write strobe
   input  wire [31:0] avs_writedata_i,          // write data
   input  wire [3:0]  avs_byteenable_i,         // byte lanes
   output reg  [31:0] avs_readdata_o,           // read data
   output wire        avs_waitrequest_o,        // stall
   // protocol engine events
   input  wire        rx_store_i,               // message stored pulse
   input  wire [4:0]  rx_store_buf_i,           // target buffer
   input  wire        rx_remote_i,              // matching remote frame pulse
   input  wire [2:0]  rx_remote_buf_i,          // buffer matched
   input  wire        tx_done_i,                // send success pulse
   input  wire        tx_lost_arb_i,            // arbitration lost pulse
   input  wire        tx_bus_err_i,             // bus error pulse
   input  wire        tx_aborted_i,             // engine confirmed abort pulse
   input  wire [2:0]  tx_event_buf_i,           // buffer for tx events
   output reg         tx_pending_o,             // a send is offered
   output reg  [2:0]  tx_pending_buf_o,         // offered buffer
   output reg  [7:0]  tx_abort_req_o,           // abort requests per buffer
   output reg         tx_extended_o,            // offered uses extended id
   output reg         tx_remote_o,              // offered is remote frame
   output reg  [28:0] tx_id_o,                  // offered identifier
   output reg  [3:0]  tx_dlc_o,                 // offered length code
   output reg         tx_hdr_valid_o,           // header fields valid
   // message ram read port
   output reg  [RAM_AW-1:0] ram_addr_o,         // word address
   input  wire [15:0] ram_rdata_i               // data one cycle later
);

   // header fetch walks the three words of
   // the offered buffer one after another;
   // the ram answers one cycle after the
   // address, so each word is taken in the
   // state that follows its address state,
   // and the length word needs a state of
   // its own after the last address
   // one-hot codes keep the decode shallow
   localparam ST_IDLE = 5'b00001;
   localparam ST_SID  = 5'b00010;
   localparam ST_EID  = 5'b00100;
   localparam ST_LEN  = 5'b01000;
   localparam ST_DLC  = 5'b10000;

   // flag banks hold 32 bits each: the low
   // half answers the first register of a
   // pair, the high half the second one
   // control bytes sit in an array, one
   // byte per transmit-capable buffer; the
   // next-value copies are built by one
   // combinational process so that software
   // and hardware updates merge in one place
   reg  [31:0] ovf_q;                           // overflow flags
   reg  [31:0] full_q;                          // full flags
   reg  [7:0]  ctl_q [0:NBUF_TX-1];             // control bytes
   reg  [7:0]  ctl_d [0:NBUF_TX-1];             // next control bytes
   reg  [7:0]  abort_d;                         // next abort requests
   reg         ack_q;                           // bus answer cycle
   reg  [4:0]  st_q;                            // fetch state
   reg  [2:0]  fetch_buf_q;                     // buffer being fetched
   reg  [15:0] sid_q;                           // captured id word
   reg  [11:0] eid_q;                           // captured eid word
   reg  [31:0] ovf_d;                           // next overflow
   reg  [31:0] full_d;                          // next full
   reg  [31:0] wmask;                           // write byte mask
   reg         best_v;                          // arbiter found one
   reg  [2:0]  best_b;                          // arbiter winner
   reg  [1:0]  best_p;                          // winner priority
   integer     i;                           // loop index, next values
   integer     j;                           // loop index, arbiter
   integer     k;                           // loop index, registers

   // bus handshake: every access costs one
   // stall cycle; the first cycle of a
   // request is the one that acts, the
   // second only answers; ack_q marks that
   // second cycle so a held write is not
   // applied twice and a held read does not
   // reload the data it is showing
   // hazard: a master that drops the strobe
   // in the stall cycle still gets its write
   // applied, since it lands on the first edge
   wire        wr_go = avs_write_i & ~ack_q;    // write accepted this cycle
   wire [5:0]  a     = avs_address_i;

   // one wait state per access
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;

   // helpers used more than once:
   // lane_mask widens byte enables so that
   // a partial write keeps unenabled bits;
   // word_addr forms the ram word address
   // of a header word, four words a buffer
   // expand byte enables to bit mask
   function [31:0] lane_mask;
      input [3:0] be;
      begin
         lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   // ram word address of a buffer field
   function [RAM_AW-1:0] word_addr;
      input [2:0] b;
      input [1:0] w;
      begin
         word_addr = {{(RAM_AW-5){1'b0}}, b, w};
      end
   endfunction

   // next values of flags and control bytes
   // order of the updates matters: software
   // writes are applied first and hardware
   // events after them, so an event that
   // falls in the same cycle as a clear
   // wins and the flag stays set
   // flag clears are write-zero: a one or a
   // disabled lane leaves the bit unchanged
   // the send request bit is software-owned
   // except for three hardware paths: done
   // and confirmed abort clear it, a remote
   // frame with auto reply enabled sets it
   // a write of zero over a pending request
   // drops the bit at once and latches an
   // abort request for the protocol engine
   always @* begin
      wmask  = lane_mask(avs_byteenable_i);
      ovf_d  = ovf_q;
      full_d = full_q;
      abort_d = tx_abort_req_o;
      for (i = 0; i < NBUF_TX; i = i + 1) begin
         ctl_d[i] = ctl_q[i];
      end
      // software side first, hardware sets override afterwards
      if (wr_go && a == {2'b00, `REG_OVF_LOW}) begin
         ovf_d[15:0] = ovf_q[15:0] & (avs_writedata_i[15:0] | ~wmask[15:0]);
      end
      if (wr_go && a == {2'b00, `REG_OVF_HIGH}) begin
         ovf_d[31:16] = ovf_q[31:16] & (avs_writedata_i[15:0] | ~wmask[15:0]);
      end
      if (wr_go && a == {2'b00, `REG_FULL_LOW}) begin
         full_d[15:0] = full_q[15:0] & (avs_writedata_i[15:0] | ~wmask[15:0]);
      end
      if (wr_go && a == {2'b00, `REG_FULL_HIGH}) begin
         full_d[31:16] = full_q[31:16] & (avs_writedata_i[15:0] | ~wmask[15:0]);
      end
      for (i = 0; i < NBUF_TX; i = i + 1) begin
         // pair register: low byte even, high byte odd
         if (wr_go && a == ({2'b00, `REG_CTRL_PAIR0} + (i / 2))
             && avs_byteenable_i[(i % 2)]) begin
            // writable fields only; status bits read-only
            ctl_d[i][`CTL_DIR_BIT] = avs_writedata_i[8*(i%2)+7];
            ctl_d[i][`CTL_RTR_BIT] = avs_writedata_i[8*(i%2)+2];
            ctl_d[i][1:0] = avs_writedata_i[8*(i%2)+:2];
            ctl_d[i][`CTL_REQ_BIT] = avs_writedata_i[8*(i%2)+3];
            if (avs_writedata_i[8*(i%2)+3] && !ctl_q[i][`CTL_REQ_BIT]) begin
               ctl_d[i][6:4] = 3'b000;
            end
            if (!avs_writedata_i[8*(i%2)+3] && ctl_q[i][`CTL_REQ_BIT]) begin
               abort_d[i] = 1'b1;
            end
         end
      end
      // hardware events
      if (rx_store_i) begin
         if (full_q[rx_store_buf_i]) begin
            ovf_d[rx_store_buf_i] = 1'b1;
         end
         full_d[rx_store_buf_i] = 1'b1;
      end
      if (rx_remote_i && ctl_q[rx_remote_buf_i][`CTL_RTR_BIT]) begin
         ctl_d[rx_remote_buf_i][`CTL_REQ_BIT] = 1'b1;
         ctl_d[rx_remote_buf_i][6:4] = 3'b000;
      end
      if (tx_done_i) begin
         ctl_d[tx_event_buf_i][`CTL_REQ_BIT] = 1'b0;
         ctl_d[tx_event_buf_i][`CTL_ABT_BIT] = 1'b0;
      end
      if (tx_lost_arb_i) begin
         ctl_d[tx_event_buf_i][`CTL_LARB_BIT] = 1'b1;
      end
      if (tx_bus_err_i) begin
         ctl_d[tx_event_buf_i][`CTL_ERR_BIT] = 1'b1;
      end
      if (tx_aborted_i) begin
         ctl_d[tx_event_buf_i][`CTL_ABT_BIT] = 1'b1;
         ctl_d[tx_event_buf_i][`CTL_REQ_BIT] = 1'b0;
         abort_d[tx_event_buf_i] = 1'b0;
      end
   end

   // arbiter: highest priority, lowest index wins
   // only transmit buffers with a request
   // and no pending abort take part; the
   // scan runs upward and replaces the
   // winner only on a strictly higher
   // priority, which leaves ties with the
   // lower buffer number
   // the result is registered before it is
   // offered, so the engine sees a stable
   // choice for at least one cycle
   always @* begin
      best_v = 1'b0;
      best_b = 3'h0;
      best_p = 2'h0;
      for (j = 0; j < NBUF_TX; j = j + 1) begin
         if (ctl_q[j][`CTL_DIR_BIT] && ctl_q[j][`CTL_REQ_BIT] && !tx_abort_req_o[j]
             && (!best_v || ctl_q[j][1:0] > best_p)) begin
            best_v = 1'b1;
            best_b = j[2:0];
            best_p = ctl_q[j][1:0];
         end
      end
   end

   // state registers
   // reset clears every flag, every control
   // byte and every abort request, so no
   // buffer is offered until software has
   // written a direction and a request, or
   // a direction and auto reply, after which
   // a remote frame sets the request
   // reset is synchronous: it only acts on
   // a clock edge while held low
   // all other edges copy the next values
   // built above; nothing is gated
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         ovf_q <= 32'h00000000;
         full_q <= 32'h00000000;
         ack_q <= 1'b0;
         tx_abort_req_o <= 8'h00;
         tx_pending_o <= 1'b0;
         tx_pending_buf_o <= 3'h0;
         for (k = 0; k < NBUF_TX; k = k + 1) begin
            ctl_q[k] <= `CTL_RESET;
         end
      end else begin
         ovf_q <= ovf_d;
         full_q <= full_d;
         ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
         tx_abort_req_o <= abort_d;
         tx_pending_o <= best_v;
         tx_pending_buf_o <= best_b;
         for (k = 0; k < NBUF_TX; k = k + 1) begin
            ctl_q[k] <= ctl_d[k];
         end
      end
   end

   // read data, registered on the accept cycle
   // the value is loaded on the first edge
   // of a read, at the end of the stall
   // cycle, and stands through the answer
   // cycle, until the next read loads it again
   // sixteen-bit registers read in the low
   // half; the upper half reads zero
   // unmapped words read zero, and writes
   // to them are dropped without an error
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (avs_read_i && !ack_q) begin
         case (a)
            {2'b00, `REG_OVF_LOW}:   avs_readdata_o <= {16'h0000, ovf_q[15:0]};
            {2'b00, `REG_OVF_HIGH}:  avs_readdata_o <= {16'h0000, ovf_q[31:16]};
            {2'b00, `REG_FULL_LOW}:  avs_readdata_o <= {16'h0000, full_q[15:0]};
            {2'b00, `REG_FULL_HIGH}: avs_readdata_o <= {16'h0000, full_q[31:16]};
            6'h04: avs_readdata_o <= {16'h0000, ctl_q[1], ctl_q[0]};
            6'h05: avs_readdata_o <= {16'h0000, ctl_q[3], ctl_q[2]};
            6'h06: avs_readdata_o <= {16'h0000, ctl_q[5], ctl_q[4]};
            6'h07: avs_readdata_o <= {16'h0000, ctl_q[7], ctl_q[6]};
            {2'b00, `REG_TX_STATUS}:
               avs_readdata_o <= {20'h00000, tx_abort_req_o, tx_pending_o, tx_pending_buf_o};
            default: avs_readdata_o <= 32'h00000000;                    // unmapped
         endcase
      end
   end

   // fetch the offered buffer's header from message ram
   // a new fetch starts whenever the offer
   // moves to another buffer or the header
   // is not valid yet; header valid drops
   // at the start so the engine never sees
   // a mix of two buffers
   // timeline: address of the id word on
   // entry to ST_SID, id word in ST_EID,
   // extended word in ST_LEN and the length
   // word in ST_DLC, where the outputs load
   // limitation: an offer that changes in
   // mid-fetch is only picked up once the
   // current fetch has finished
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_q <= ST_IDLE;
         fetch_buf_q <= 3'h0;
         ram_addr_o <= {RAM_AW{1'b0}};
         sid_q <= 16'h0000;
         eid_q <= 12'h000;
         tx_extended_o <= 1'b0;
         tx_remote_o <= 1'b0;
         tx_id_o <= 29'h00000000;
         tx_dlc_o <= 4'h0;
         tx_hdr_valid_o <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               // refetch whenever offer changes
               if (best_v && (!tx_hdr_valid_o || best_b != fetch_buf_q)) begin
                  tx_hdr_valid_o <= 1'b0;
                  fetch_buf_q <= best_b;
                  ram_addr_o <= word_addr(best_b, `WORD_SID);
                  st_q <= ST_SID;
               end else if (!best_v) begin
                  tx_hdr_valid_o <= 1'b0;
               end
            end
            ST_SID: begin
               ram_addr_o <= word_addr(fetch_buf_q, `WORD_EID);
               st_q <= ST_EID;
            end
            ST_EID: begin
               sid_q <= ram_rdata_i & 16'h1FFF;
               ram_addr_o <= word_addr(fetch_buf_q, `WORD_LEN);
               st_q <= ST_LEN;
            end
            ST_LEN: begin
               eid_q <= ram_rdata_i[`EID_WORD_MSB:0];
               st_q <= ST_DLC;
            end
            ST_DLC: begin
               // length word stands now
               tx_extended_o <= sid_q[`SID_IDE_BIT];
               tx_remote_o <= sid_q[`SID_IDE_BIT] ? ram_rdata_i[`LEN_RTR_BIT]
                                                  : sid_q[`SID_SRR_BIT];
               tx_id_o <= {sid_q[`SID_MSB:`SID_LSB], eid_q,
                           ram_rdata_i[`LEN_EID_MSB:`LEN_EID_LSB]};
               tx_dlc_o <= ram_rdata_i[`LEN_DLC_MSB:0];
               tx_hdr_valid_o <= 1'b1;
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// [include/can_buf_defines.vh]
`ifndef CAN_BUF_DEFINES_VH
`define CAN_BUF_DEFINES_VH
// register word offsets (byte addresses = index * 4)
`define REG_OVF_LOW        4'h0
`define REG_OVF_HIGH       4'h1
`define REG_FULL_LOW       4'h2
`define REG_FULL_HIGH      4'h3
`define REG_CTRL_PAIR0     4'h4
`define REG_TX_STATUS      4'hC
// control byte fields
`define CTL_DIR_BIT        7
`define CTL_ABT_BIT        6
`define CTL_LARB_BIT       5
`define CTL_ERR_BIT        4
`define CTL_REQ_BIT        3
`define CTL_RTR_BIT        2
`define CTL_PRI_HI         1
`define CTL_PRI_LO         0
`define CTL_RESET          8'h00
// buffer identifier word fields
`define SID_MSB            12
`define SID_LSB            2
`define SID_SRR_BIT        1
`define SID_IDE_BIT        0
`define EID_WORD_MSB       11
`define LEN_EID_MSB        15
`define LEN_EID_LSB        10
`define LEN_RTR_BIT        9
`define LEN_RB_HIGH_BIT    8
`define LEN_RB_LOW_BIT     4
`define LEN_DLC_MSB        3
// buffer word indices in message ram
`define WORD_SID           2'h0
`define WORD_EID           2'h1
`define WORD_LEN           2'h2
`endif

// [verification/buf_ctrl_properties.sv]
`default_nettype none
module buf_ctrl_props #(
   parameter RAM_AW = 8                         // message ram address width
) (
   input wire logic              ref_clk_i,     // system clock
   input wire logic              rst_b_i,       // sync reset, active low
   input wire logic [5:0]        avs_address_i, // word address
   input wire logic              avs_read_i,    // read strobe
   input wire logic              avs_write_i,   // write strobe
   input wire logic [31:0]       avs_readdata_o,    // read data
   input wire logic              avs_waitrequest_o, // stall
   input wire logic              tx_aborted_i,      // engine abort pulse
   input wire logic [2:0]        tx_event_buf_i,    // event buffer
   input wire logic              tx_pending_o,      // offer valid
   input wire logic [2:0]        tx_pending_buf_o,  // offered buffer
   input wire logic [7:0]        tx_abort_req_o,    // abort requests
   input wire logic              tx_hdr_valid_o,    // header valid
   input wire logic [RAM_AW-1:0] ram_addr_o         // ram word address
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // a fresh bus request
   sequence req_start;
      $rose(avs_read_i || avs_write_i);
   endsequence
   // exactly one stall cycle
   sequence one_wait;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   // a new buffer offered to the bus
   sequence new_offer;
      $rose(tx_pending_o) or (tx_pending_o && $changed(tx_pending_buf_o));
   endsequence
   chk_bus_one_wait: assert property (req_start |-> one_wait)
      else $error("bus answer not after one stall cycle");
   chk_upper_half_zero: assert property (
      avs_read_i && !avs_waitrequest_o && avs_address_i != 6'h0C
      |-> avs_readdata_o[31:16] == 16'h0000) else $error("upper half not zero");
   chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i > 6'h07 && avs_address_i != 6'h0C |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_status_mirror: assert property (
      avs_read_i && !avs_waitrequest_o && avs_address_i == 6'h0C |-> avs_readdata_o[11:0]
      == {$past(tx_abort_req_o), $past(tx_pending_o), $past(tx_pending_buf_o)})
      else $error("status read differs from outputs");
   chk_abort_clear: assert property (
      tx_aborted_i && tx_abort_req_o[tx_event_buf_i]
      |=> !tx_abort_req_o[$past(tx_event_buf_i)]) else $error("abort request kept");
   chk_abort_cause: assert property (
      |(tx_abort_req_o & ~$past(tx_abort_req_o))
      |-> $past(avs_write_i) && $past(avs_address_i) inside {[6'h04:6'h07]})
      else $error("abort request without control write");
   chk_hdr_fetch_addr: assert property (
      new_offer |-> ##[0:3] ram_addr_o == {{(RAM_AW-5){1'b0}}, tx_pending_buf_o, 2'h0})
      else $error("header fetch address wrong");
   chk_hdr_valid_bound: assert property ($rose(tx_pending_o) |-> ##[1:8] tx_hdr_valid_o)
      else $error("header not valid in time");
endmodule
bind can_message_buffer_control buf_ctrl_props #(.RAM_AW(RAM_AW)) u_props (.*);
`default_nettype wire

// [verification/msg_ram_model.sv]
`default_nettype none
module msg_ram_model #(
   parameter RAM_AW = 8                         // word address width
) (
   input  wire logic              ref_clk_i,    // system clock
   input  wire logic [RAM_AW-1:0] ram_addr_i,   // word address
   output var  logic [15:0]       ram_rdata_o   // data one cycle later
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem_q [0:(1<<RAM_AW)-1];        // four words per buffer
   // headers of buffers 3 and 5, all else zero
   initial begin
      foreach (mem_q[i]) mem_q[i] = 16'h0000;
      mem_q[12] = {3'h0, 11'h5A3, 1'b0, 1'b1};  // sid, srr, ide
      mem_q[13] = 16'h0ABC;                      // upper extended id
      mem_q[14] = {6'h2D, 1'b1, 1'b0, 3'h0, 1'b0, 4'h5};
      mem_q[20] = {3'h0, 11'h123, 1'b1, 1'b0};  // standard with srr
      mem_q[22] = 16'h0008;                      // eight bytes
   end
   // synchronous read port
   always @(posedge ref_clk_i) begin
      ram_rdata_o <= mem_q[ram_addr_i];
   end
endmodule
`default_nettype wire

// [verification/tb.sv]
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i = 1'b0;               // system clock
   logic        rst_b_i = 1'b0;                 // reset, active low
   logic [5:0]  avs_address_i = 6'h00;          // bus request fields
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic [3:0]  avs_byteenable_i = 4'hF;
   logic [4:0]  ev_buf = 5'h00;                 // buffer of an engine event
   logic [5:0]  ev = 6'h00;                     // one-hot engine events
   logic [31:0] avs_readdata_o, rdv;
   logic        avs_waitrequest_o, tx_pending_o, tx_extended_o, tx_remote_o, tx_hdr_valid_o;
   logic [2:0]  tx_pending_buf_o;
   logic [7:0]  tx_abort_req_o, ram_addr_o;
   logic [28:0] tx_id_o;
   logic [3:0]  tx_dlc_o;
   logic [15:0] ram_rdata_i;
   int          num_errors = 0;
   int          tests_run = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   can_message_buffer_control dut (.rx_store_i(ev[0]), .rx_remote_i(ev[1]), .tx_done_i(ev[2]),
      .tx_lost_arb_i(ev[3]), .tx_bus_err_i(ev[4]), .tx_aborted_i(ev[5]),
      .rx_store_buf_i(ev_buf), .rx_remote_buf_i(ev_buf[2:0]), .tx_event_buf_i(ev_buf[2:0]), .*);
   msg_ram_model peer (.ref_clk_i(ref_clk_i), .ram_addr_i(ram_addr_o), .ram_rdata_o(ram_rdata_i));
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one clock of a bounded wait
   task automatic tick(inout int n);
      @(negedge ref_clk_i);
      n++;
      if (n > 60) begin
         num_errors++;
         $display("MISMATCH t=%0t wait ran out", $time);
         report_and_stop();
      end
   endtask
   // one bus transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n = 0;
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      tick(n);
      while (avs_waitrequest_o !== 1'b0) tick(n);
      rdv = avs_readdata_o;
      @(posedge ref_clk_i);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000, 4'hF);
      check(rdv, exp);
   endtask
   // one-cycle engine event: 0 store 1 remote 2 done 3 lost 4 error 5 aborted
   task automatic pulse(input int k, input logic [4:0] b);
      ev_buf <= b;
      ev <= 6'h01 << k;
      @(posedge ref_clk_i);
      ev <= 6'h00;
      repeat (2) @(posedge ref_clk_i);
   endtask
   // wait for an offer and its header, compare {ext, remote, sid, dlc}
   task automatic hdr(input logic [2:0] b, input logic [16:0] exp);
      int n = 0;
      while (!(tx_pending_o === 1'b1 && tx_pending_buf_o === b)) tick(n);
      while (ram_addr_o !== {3'h0, b, 2'h2}) tick(n);
      while (tx_hdr_valid_o !== 1'b1) tick(n);
      check({tx_extended_o, tx_remote_o, tx_id_o[28:18], tx_dlc_o}, {15'h0000, exp});
      @(posedge ref_clk_i);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      for (int a = 0; a < 8; a++) rdchk(a[5:0], 32'h00000000);
      bus(1'b1, 6'h20, 32'hFFFFFFFF, 4'hF);
      rdchk(6'h20, 32'h00000000);
      pulse(0, 5'h03);
      rdchk(6'h02, 32'h00000008);
      rdchk(6'h00, 32'h00000000);
      pulse(0, 5'h03);
      pulse(0, 5'h14);
      pulse(0, 5'h14);
      rdchk(6'h00, 32'h00000008);
      rdchk(6'h01, 32'h00000010);
      bus(1'b1, 6'h00, 32'h0000FFFF, 4'hF);
      rdchk(6'h00, 32'h00000008);
      bus(1'b1, 6'h00, 32'h00000000, 4'hF);
      rdchk(6'h00, 32'h00000000);
      rdchk(6'h01, 32'h00000010);
      bus(1'b1, 6'h04, 32'h0000000B, 4'hF);
      bus(1'b1, 6'h05, 32'h00008B8B, 4'hF);
      bus(1'b1, 6'h06, 32'h00008900, 4'hF);
      hdr(3'h2, 17'h00000);
      pulse(2, 5'h02);
      rdchk(6'h05, 32'h00008B83);
      hdr(3'h3, {2'h3, 11'h5A3, 4'h5});
      check({14'h0000, tx_id_o[17:0]}, {14'h0000, 12'hABC, 6'h2D});
      pulse(2, 5'h03);
      hdr(3'h5, {2'h1, 11'h123, 4'h8});
      pulse(3, 5'h05);
      pulse(4, 5'h05);
      rdchk(6'h06, 32'h0000B900);
      bus(1'b1, 6'h06, 32'h00008100, 4'h2);
      check({24'h000000, tx_abort_req_o}, 32'h00000020);
      rdchk(6'h06, 32'h0000B100);
      rdchk(6'h0C, 32'h00000200);
      pulse(5, 5'h05);
      rdchk(6'h06, 32'h0000F100);
      check({24'h000000, tx_abort_req_o}, 32'h00000000);
      bus(1'b1, 6'h06, 32'h00008900, 4'h2);
      rdchk(6'h06, 32'h00008900);
      hdr(3'h5, {2'h1, 11'h123, 4'h8});
      pulse(2, 5'h05);
      rdchk(6'h06, 32'h00008100);
      check({31'h00000000, tx_pending_o}, 32'h00000000);
      rdchk(6'h04, 32'h0000000B);
      bus(1'b1, 6'h07, 32'h00008084, 4'h3);
      pulse(1, 5'h06);
      rdchk(6'h07, 32'h0000808C);
      pulse(1, 5'h07);
      rdchk(6'h07, 32'h0000808C);
      hdr(3'h6, 17'h00000);
      report_and_stop();
   end
endmodule
`default_nettype wire
